// ---- rtl/buck_ctrl_pkg.sv ----
package buck_ctrl_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [1:0] BUCK1_CONTROL_OFS = 2'h0;
  localparam logic [1:0] BUCK2_CONTROL_OFS = 2'h1;
  localparam logic [1:0] BUCK3_CONTROL_OFS = 2'h2;
  localparam logic [1:0] BUCK4_CONTROL_OFS = 2'h3;

  // ---------------------------------------------------------------
  // field positions and writable masks
  // ---------------------------------------------------------------
  localparam int SELECT_BIT = 7;
  localparam int RANGE_LSB  = 5;
  localparam int STEP_LSB   = 2;
  localparam int MODE_BIT   = 1;
  localparam int RAMP_BIT   = 0;
  localparam logic [7:0] BUCK1_WR_MASK = 8'hfe;
  localparam logic [7:0] BUCKX_WR_MASK = 8'h1e;
  localparam logic [7:0] BUCK4_WR_MASK = 8'h1f;

  // ---------------------------------------------------------------
  // reset defaults, one per strap level for buck1 and buck4, one shared by buck2 and buck3
  // ---------------------------------------------------------------
  localparam logic [7:0] BUCK1_RST_LO = 8'h02;
  localparam logic [7:0] BUCK1_RST_HI = 8'h02;
  localparam logic [7:0] BUCKX_RST    = 8'h00;
  localparam logic [7:0] BUCK4_RST_LO = 8'h01;
  localparam logic [7:0] BUCK4_RST_HI = 8'h01;

  // ---------------------------------------------------------------
  // pin-scaling ranges: step size in 0.5 mV units, step count
  // ---------------------------------------------------------------
  localparam logic [5:0] RANGE0_STEPS = 6'h18;
  localparam logic [5:0] RANGEX_STEPS = 6'h20;
  localparam logic [5:0] RANGE0_SIZE  = 6'h32;
  localparam logic [5:0] RANGEX_SIZE  = 6'h19;

  // ---------------------------------------------------------------
  // timing: 200 MHz clock, ramps
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int RAMP_SLOW_US   = 200;
  localparam int RAMP_FAST_US   = 60;
  localparam int RAMP_SLOW_CYC  = RAMP_SLOW_US * CLK_MHZ;
  localparam int RAMP_FAST_CYC  = RAMP_FAST_US * CLK_MHZ;

  // step size that the sequencer moves per increment, in mV tenths
  localparam int STEP_TENTHS_MV = 125;

  // cycles per 12.5 mV step: 12.5 / rate(mV/us) * CLK_MHZ
  function automatic logic [15:0] step_cycles(input logic [2:0] code);
    int rateHundredths;
    case (code)
      3'h0:    rateHundredths = 3000;
      3'h1:    rateHundredths = 1250;
      3'h2:    rateHundredths = 940;
      3'h3:    rateHundredths = 750;
      3'h4:    rateHundredths = 625;
      3'h5:    rateHundredths = 470;
      3'h6:    rateHundredths = 312;
      default: rateHundredths = 250;
    endcase
    step_cycles = 16'((STEP_TENTHS_MV * 10 * CLK_MHZ) / rateHundredths);
  endfunction : step_cycles

endpackage : buck_ctrl_pkg

// ---- rtl/step_sequencer.sv ----
`timescale 1ns/1ps
// one converter's stepped voltage sequencer
module step_sequencer
  import buck_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // control
  input  wire logic [2:0] slewCode,
  input  wire logic [5:0] targetCode,
  // state
  output logic [5:0]      levelCode,
  output logic            stepBusy
);

  typedef struct packed {
    logic [15:0] timer;  // cycles left in current step
    logic [5:0]  level;  // present voltage code
  } seq_t;

  seq_t seq_r;
  seq_t seq_nxt;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    seq_nxt = seq_r;
    if (seq_r.level == targetCode) begin
      // idle: timer kept clear so a new target takes its first step on the next cycle
      seq_nxt.timer = '0;
    end else if (seq_r.timer == 16'h0000) begin
      if (seq_r.level < targetCode) begin
        seq_nxt.level = seq_r.level + 6'h01;
      end else begin
        seq_nxt.level = seq_r.level - 6'h01;
      end
      seq_nxt.timer = step_cycles(slewCode) - 16'h0001;
    end else begin
      seq_nxt.timer = seq_r.timer - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_r <= '0;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  assign levelCode = seq_r.level;
  assign stepBusy  = (seq_r.level != targetCode);

endmodule : step_sequencer

// ---- rtl/buck_converter_control_regs.sv ----
`timescale 1ns/1ps
// four buck control registers with steppers and mode outputs
module buck_converter_control_regs
  import buck_ctrl_pkg::*;
#(
  parameter int RAMP_SLOW = RAMP_SLOW_CYC,
  parameter int RAMP_FAST = RAMP_FAST_CYC
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // strap choosing the default bank
  input  wire logic       configStrap,
  // register port from the serial interface
  input  wire logic [1:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic [7:0]      regRdata,
  // converter 1 voltage sources
  input  wire logic [5:0] buck1RegCode,
  input  wire logic       buck1LowPowerReq,
  input  wire logic       opAltSelectPin,
  input  wire logic [5:0] buck1AltCode,
  input  wire logic       opAltPinEnable,
  input  wire logic [5:0] scalingPinCode,
  // targets for converters 2..4
  input  wire logic [5:0] buck2Target,
  input  wire logic [5:0] buck3Target,
  input  wire logic [5:0] buck4Target,
  // start request for converter 4
  input  wire logic       buck4Start,
  // converter outputs
  output logic [3:0]      pwmForce,
  output logic            lowPowerFlag,
  output logic            pinScalingActive,
  output logic [1:0]      activeRange,
  output logic [5:0]      buck1Level,
  output logic [5:0]      buck2Level,
  output logic [5:0]      buck3Level,
  output logic [5:0]      buck4Level,
  output logic [5:0]      rangeStepCount,
  output logic [5:0]      rangeStepSize,
  output logic [3:0]      stepBusy,
  output logic            buck4RampDone
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_RUN  = 2'b01,
    RAMP_DONE = 2'b11
  } ramp_t;

  typedef struct packed {
    logic [2:0]  strapSync;   // three-stage strap synchroniser
    logic [2:0]  fillSh;      // ones walk in as the synchroniser fills
    logic        strapTaken;  // defaults loaded after release
    logic [7:0]  ctl1;        // buck1_control
    logic [7:0]  ctl2;        // buck2_control
    logic [7:0]  ctl3;        // buck3_control
    logic [7:0]  ctl4;        // buck4_control
    logic [7:0]  rdata;       // read data
    ramp_t       ramp;        // buck4 start-up ramp state
    logic [15:0] rampCnt;     // ramp cycles left
    logic [5:0]  tgt1;        // converter 1 selected target
    logic [3:0]  pwm;         // forced-PWM outputs
    logic        lowPow;      // low-power flag
    logic        pinSel;      // pin scaling active
    logic [1:0]  rng;         // active range
    logic [5:0]  stCount;     // range step count
    logic [5:0]  stSize;      // range step size
    logic [23:0] lvl;         // levels of converters 1..3 + spare
    logic [5:0]  lvl4;        // level of converter 4
    logic [3:0]  busy;        // sequencers moving
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // sequencer results
  logic [5:0] seqLevel [4];
  logic [3:0] seqBusy;
  logic [5:0] seqTarget [4];

  // strap read on agreement of the second and third stage
  function automatic logic [7:0] pick(input logic hi, input logic [7:0] a,
                                      input logic [7:0] b);
    pick = hi ? b : a;
  endfunction : pick

  // masked write keeping reserved bits zero
  function automatic logic [7:0] wr(input logic [7:0] d,
                                    input logic [7:0] m);
    wr = d & m;
  endfunction : wr

  // ---------------------------------------------------------------
  // steppers, one per converter
  // ---------------------------------------------------------------
  assign seqTarget[0] = st_r.tgt1;
  assign seqTarget[1] = buck2Target;
  assign seqTarget[2] = buck3Target;
  // converter 4 holds at zero until its start-up ramp finishes
  assign seqTarget[3] = (st_r.ramp == RAMP_DONE) ? buck4Target : '0;

  for (genvar g = 0; g < 4; g++) begin : gSeq
    logic [2:0] code;
    always_comb begin
      case (g)
        0:       code = st_r.ctl1[STEP_LSB +: 3];
        1:       code = st_r.ctl2[STEP_LSB +: 3];
        2:       code = st_r.ctl3[STEP_LSB +: 3];
        default: code = st_r.ctl4[STEP_LSB +: 3];
      endcase
    end
    step_sequencer uSeq (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .slewCode   (code),
      .targetCode (seqTarget[g]),
      .levelCode  (seqLevel[g]),
      .stepBusy   (seqBusy[g])
    );
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic strapHi;
    logic [1:0] r;
    strapHi = st_r.strapSync[2];
    r = 2'b00;
    st_nxt = st_r;
    st_nxt.strapSync = {st_r.strapSync[1:0], configStrap};
    st_nxt.fillSh    = {st_r.fillSh[1:0], 1'b1};

    // defaults from strap bank once settled
    // the reset zeros in the synchroniser must not count as agreement,
    // so the bank is chosen only once the pin has reached stage three
    if (!st_r.strapTaken) begin
      if (st_r.fillSh[2] && (st_r.strapSync[2] == st_r.strapSync[1])) begin
        st_nxt.strapTaken = 1'b1;
        st_nxt.ctl1 = pick(strapHi, BUCK1_RST_LO, BUCK1_RST_HI);
        st_nxt.ctl2 = BUCKX_RST;
        st_nxt.ctl3 = BUCKX_RST;
        st_nxt.ctl4 = pick(strapHi, BUCK4_RST_LO, BUCK4_RST_HI);
      end
    end else if (regWrite) begin
      case (regAddr)
        BUCK1_CONTROL_OFS: st_nxt.ctl1 = wr(regWdata, BUCK1_WR_MASK);
        BUCK2_CONTROL_OFS: st_nxt.ctl2 = wr(regWdata, BUCKX_WR_MASK);
        BUCK3_CONTROL_OFS: st_nxt.ctl3 = wr(regWdata, BUCKX_WR_MASK);
        default:           st_nxt.ctl4 = wr(regWdata, BUCK4_WR_MASK);
      endcase
    end

    // read path, registered
    if (regRead) begin
      case (regAddr)
        BUCK1_CONTROL_OFS: st_nxt.rdata = st_r.ctl1;
        BUCK2_CONTROL_OFS: st_nxt.rdata = st_r.ctl2;
        BUCK3_CONTROL_OFS: st_nxt.rdata = st_r.ctl3;
        default:           st_nxt.rdata = st_r.ctl4;
      endcase
    end

    // converter 1 source selection
    st_nxt.pinSel = st_r.ctl1[SELECT_BIT];
    if (st_r.ctl1[SELECT_BIT]) begin
      // pins drive, range forced, register ignored
      r = 2'b00;
      st_nxt.tgt1 = scalingPinCode;
    end else begin
      r = st_r.ctl1[RANGE_LSB +: 2];
      st_nxt.tgt1 = (opAltPinEnable && opAltSelectPin) ? buck1AltCode
                                                        : buck1RegCode;
    end
    st_nxt.rng = r;

    if (r == 2'b00) begin
      st_nxt.stCount = RANGE0_STEPS;
      st_nxt.stSize  = RANGE0_SIZE;
    end else begin
      st_nxt.stCount = RANGEX_STEPS;
      st_nxt.stSize  = RANGEX_SIZE;
    end
    // clamp pin code to the range's step count
    if (st_r.ctl1[SELECT_BIT] && scalingPinCode >= RANGE0_STEPS) begin
      st_nxt.tgt1 = RANGE0_STEPS - 6'h01;
    end

    st_nxt.pwm = {st_r.ctl4[MODE_BIT], st_r.ctl3[MODE_BIT],
                  st_r.ctl2[MODE_BIT], st_r.ctl1[MODE_BIT]};
    // low power only in auto mode
    st_nxt.lowPow = buck1LowPowerReq && !st_r.ctl1[MODE_BIT];

    case (st_r.ramp)
      RAMP_IDLE: begin
        if (buck4Start && st_r.strapTaken) begin
          st_nxt.ramp = RAMP_RUN;
          // slow ramp is a least time, fast ramp a longest time
          st_nxt.rampCnt = st_r.ctl4[RAMP_BIT] ? 16'(RAMP_FAST - 1)
                                               : 16'(RAMP_SLOW - 1);
        end
      end
      RAMP_RUN: begin
        if (st_r.rampCnt == 16'h0000) begin
          st_nxt.ramp = RAMP_DONE;
        end else begin
          st_nxt.rampCnt = st_r.rampCnt - 16'h0001;
        end
      end
      RAMP_DONE: begin
        if (!buck4Start) begin
          st_nxt.ramp = RAMP_IDLE;
        end
      end
      default: st_nxt.ramp = RAMP_IDLE;
    endcase

    st_nxt.lvl  = {6'h00, seqLevel[2], seqLevel[1], seqLevel[0]};
    st_nxt.lvl4 = seqLevel[3];
    st_nxt.busy = seqBusy;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flops, except buck4RampDone, which is decoded from the ramp state
  // ---------------------------------------------------------------
  assign regRdata         = st_r.rdata;
  assign pwmForce         = st_r.pwm;
  assign lowPowerFlag     = st_r.lowPow;
  assign pinScalingActive = st_r.pinSel;
  assign activeRange      = st_r.rng;
  assign buck1Level       = st_r.lvl[5:0];
  assign buck2Level       = st_r.lvl[11:6];
  assign buck3Level       = st_r.lvl[17:12];
  assign buck4Level       = st_r.lvl4;
  assign rangeStepCount   = st_r.stCount;
  assign rangeStepSize    = st_r.stSize;
  assign stepBusy         = st_r.busy;
  assign buck4RampDone    = (st_r.ramp == RAMP_DONE);

endmodule : buck_converter_control_regs

// ---- verif/buck_ctrl_sva.sv ----
`timescale 1ns/1ps
// port-level checks for the buck control register block
module buck_ctrl_sva
  import buck_ctrl_pkg::*;
#(
  parameter int RAMP_SLOW = RAMP_SLOW_CYC,
  parameter int RAMP_FAST = RAMP_FAST_CYC
)(
  // clock and reset
  input logic       clk,
  input logic       sys_rst,
  // register port
  input logic [1:0] regAddr,
  input logic       regWrite,
  input logic       regRead,
  input logic [7:0] regWdata,
  input logic [7:0] regRdata,
  // converter side
  input logic       buck4Start,
  input logic [3:0] pwmForce,
  input logic       lowPowerFlag,
  input logic       buck1LowPowerReq,
  input logic       pinScalingActive,
  input logic [1:0] activeRange,
  input logic [5:0] buck2Level,
  input logic [5:0] buck4Level,
  input logic [5:0] rangeStepCount,
  input logic [5:0] rangeStepSize,
  input logic       buck4RampDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ramp length; a counter because the slow ramp is far beyond any delay
  logic [31:0] rampCnt_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rampCnt_r <= '0;
    else if (!buck4Start) rampCnt_r <= '0;
    else if (!buck4RampDone) rampCnt_r <= rampCnt_r + 32'h1;
  end
  a_reserved_bit_read_zero: assert property (
    regRead |=> (regRdata & ~(($past(regAddr) == 2'h0) ? 8'hfe :
      ($past(regAddr) == 2'h3) ? 8'h1f : 8'h1e)) == 8'h00)
    else $error("reserved bit read back set");
  a_pin_select: assert property (
    regWrite && regAddr == 2'h0 ##1 !regWrite |=>
    pinScalingActive == $past(regWdata[7], 2))
    else $error("pin scaling select not following register");
  a_mode_write: assert property (
    regWrite ##1 !regWrite |=>
    pwmForce[$past(regAddr, 2)] == $past(regWdata[1], 2))
    else $error("forced pwm bit not following register");
  a_range_forced: assert property (
    pinScalingActive |-> activeRange == 2'h0)
    else $error("range not forced while pins scale");
  a_range_low: assert property (
    activeRange == 2'h0 [*8] |->
    rangeStepCount == 6'h18 && rangeStepSize == 6'h32)
    else $error("range zero step table wrong");
  a_range_fine: assert property (
    activeRange != 2'h0 [*8] |->
    rangeStepCount == 6'h20 && rangeStepSize == 6'h19)
    else $error("fine range step table wrong");
  a_eco_gate: assert property (
    pwmForce[0] [*2] |-> !lowPowerFlag)
    else $error("low power flag set in forced pwm");
  a_eco_follow: assert property (
    (!pwmForce[0] && buck1LowPowerReq) [*3] |-> lowPowerFlag)
    else $error("low power flag missing in auto mode");
  a_single_step: assert property (
    buck2Level != $past(buck2Level) |->
    6'(buck2Level - $past(buck2Level)) inside {6'h01, 6'h3f})
    else $error("level moved by more than one step");
  a_step_spacing: assert property (
    $changed(buck2Level) |=> $stable(buck2Level) [*8])
    else $error("level steps too close together");
  a_ramp_hold: assert property (
    !buck4RampDone [*2] |-> buck4Level == 6'h00)
    else $error("buck4 level moved before ramp done");
  a_ramp_bound: assert property (
    rampCnt_r <= RAMP_SLOW + 8)
    else $error("buck4 ramp too long");
  a_reset_clear: assert property (
    $fell(sys_rst) |-> pwmForce == 4'h0 && !pinScalingActive)
    else $error("outputs not cleared by reset");
  c_pin_write: cover property (regWrite && regAddr == 2'h0);
  c_ramp_done: cover property ($rose(buck4RampDone));
  c_step: cover property ($changed(buck2Level));
endmodule : buck_ctrl_sva

bind buck_converter_control_regs buck_ctrl_sva #(
  .RAMP_SLOW(RAMP_SLOW), .RAMP_FAST(RAMP_FAST)) i_sva (
  .clk, .sys_rst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
  .buck4Start, .pwmForce, .lowPowerFlag, .buck1LowPowerReq,
  .pinScalingActive, .activeRange, .buck2Level, .buck4Level,
  .rangeStepCount, .rangeStepSize, .buck4RampDone);

// ---- verif/buck_converter_control_regs_tb.sv ----
`timescale 1ns/1ps
// register, stepper and ramp bench for the buck control block
module buck_converter_control_regs_tb
  import buck_ctrl_pkg::*;
;
  // short ramps keep the run brief
  localparam int RS = 20;
  localparam int RF = 6;
  logic       clk, sys_rst, configStrap, regWrite, regRead, buck4Start;
  logic       buck1LowPowerReq, opAltSelectPin, opAltPinEnable;
  logic       lowPowerFlag, pinScalingActive, buck4RampDone, rdPend;
  logic [1:0] regAddr, activeRange, a;
  logic [3:0] pwmForce, stepBusy;
  logic [7:0] regWdata, regRdata, sh[4], expQ[$];
  logic [5:0] buck1RegCode, buck1AltCode, scalingPinCode, tgt;
  logic [5:0] buck2Target, buck3Target, buck4Target, rangeStepCount;
  logic [5:0] buck1Level, buck2Level, buck3Level, buck4Level, rangeStepSize;
  int         mismatches, n_checks, n, c, seed = 55;
  int         rate[8] = '{3000, 1250, 940, 750, 625, 470, 312, 250};

  buck_converter_control_regs #(.RAMP_SLOW(RS), .RAMP_FAST(RF)) i_dut (
    .clk, .sys_rst, .configStrap, .regAddr, .regWrite, .regRead, .regWdata,
    .regRdata, .buck1RegCode, .buck1LowPowerReq, .opAltSelectPin,
    .buck1AltCode, .opAltPinEnable, .scalingPinCode, .buck2Target,
    .buck3Target, .buck4Target, .buck4Start, .pwmForce, .lowPowerFlag,
    .pinScalingActive, .activeRange, .buck1Level, .buck2Level, .buck3Level,
    .buck4Level, .rangeStepCount, .rangeStepSize, .stepBusy, .buck4RampDone);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // the shadow copy keeps only writable bits
  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= ad;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    sh[ad] = d & ((ad == 2'h0) ? 8'hfe : (ad == 2'h3) ? 8'h1f : 8'h1e);
  endtask : wr

  // a read notes its expected byte; the monitor checks it
  task automatic rd(input logic [1:0] ad);
    @(posedge clk);
    regAddr <= ad;
    regRead <= 1'b1;
    expQ.push_back(sh[ad]);
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd

  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    sh = '{8'h02, 8'h00, 8'h00, 8'h01};
  endtask : do_reset

  // edges until buck2 level moves, bounded
  task automatic wait_change(output int cnt);
    logic [5:0] v;
    v = buck2Level;
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (buck2Level === v && cnt < 1200);
  endtask : wait_change

  // read data shows one cycle after the read edge
  always @(posedge clk) begin
    if (rdPend) chk(regRdata, expQ.pop_front());
    rdPend <= regRead;
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    {regWrite, regRead, rdPend, buck4Start, regAddr, regWdata} = '0;
    {buck1LowPowerReq, opAltSelectPin, opAltPinEnable} = '0;
    {buck1RegCode, buck1AltCode, scalingPinCode} = '0;
    {buck2Target, buck3Target, buck4Target} = '0;
    sys_rst = 1'b1;
    configStrap = 1'($random(seed));
    do_reset();
    for (n = 0; n < 4; n++) rd(2'(n));
    // random writes, readback and mode outputs
    for (n = 0; n < 24; n++) begin
      a = 2'($random(seed));
      buck1LowPowerReq <= 1'($random(seed));
      opAltSelectPin   <= 1'($random(seed));
      opAltPinEnable   <= 1'($random(seed));
      buck1RegCode     <= 6'($random(seed));
      buck1AltCode     <= 6'($random(seed));
      scalingPinCode   <= 6'($random(seed));
      buck3Target      <= 6'($random(seed));
      wr(a, 8'($random(seed)));
      rd(a);
      repeat (3) @(posedge clk);
      chk(pwmForce, {sh[3][1], sh[2][1], sh[1][1], sh[0][1]});
      chk(pinScalingActive, sh[0][7]);
      chk(lowPowerFlag, buck1LowPowerReq & ~sh[0][1]);
    end
    // step period for every slew code: 12.5 mV at 200 cycles per us
    for (n = 0; n < 8; n++) begin
      wr(2'h1, {3'h0, 3'(n), 2'h0});
      tgt = (buck2Level == 6'h00) ? 6'h02 : 6'h00;
      buck2Target <= tgt;
      wait_change(c);
      wait_change(c);
      chk(c >= 250000 / rate[n] - 2 && c <= 250000 / rate[n] + 2, 1);
      chk(buck2Level, tgt);
    end
    // both start-up ramp choices, each after a fresh reset
    for (n = 0; n < 2; n++) begin
      buck4Start <= 1'b0;
      do_reset();
      wr(2'h3, {7'h0, 1'(n)});
      buck4Target <= 6'h01;
      buck4Start  <= 1'b1;
      c = 0;
      while (buck4RampDone !== 1'b1 && c < 100) begin
        @(posedge clk);
        c++;
      end
      chk((n == 1) ? (c <= RF + 4) : (c >= RS && c <= RS + 4), 1);
    end
    report_and_stop();
  end
endmodule : buck_converter_control_regs_tb
